// File: eeprom_link_pkg.sv
// Purpose: shared constants and types for the two-wire serial eeprom link
// Assumes: 40 MHz system clock; link clock made by the host end
// Notes: WORD_BITS is used by both the device end and the host end; the other widths and counts by one end only
package eeprom_link_pkg;
  localparam int WORD_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam int WORD_ADDR_W = 15;
  localparam int PAGE_AW = 6;
  localparam int PAGE_BYTES = 64;
  localparam int STRAP_W = 3;
  localparam int TYPE_LSB = 4;
  localparam int STRAP_LSB = 1;
  localparam int RW_POS = 0;
  localparam int HI_ADDR_W = WORD_ADDR_W - WORD_BITS;
  // internal write cycle time in ns and the system clock period in ns
  localparam int INTERNAL_WRITE_CYCLE_TIME_NS = 5000000;
  localparam int MCLK_PERIOD_NS = 25;
  localparam int TWR_CYCLES_DFLT = INTERNAL_WRITE_CYCLE_TIME_NS / MCLK_PERIOD_NS;
  localparam int QUARTER_CYCLES_DFLT = 10;
  localparam int SOFT_RESET_CLOCKS = 9;

  typedef enum logic [2:0] {ph_idle, ph_dev, ph_addr_hi, ph_addr_lo, ph_data} dev_phase_t;
  typedef enum logic [1:0] {op_start, op_stop, op_write, op_clocks} host_op_t;
  typedef enum logic [1:0] {st_idle, st_start, st_stop, st_bit} host_state_t;
endpackage

// File: eeprom_link_if.sv
// Purpose: two-wire link between host end and eeprom device end
// Assumes: data line is open drain with a pull-up; clock line driven by host only
// Notes: the line level is resolved here from both ends' enables
`timescale 1ns/1ps
interface eeprom_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;

  // pull-up wins unless an end drives a low
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

  modport host (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// File: eeprom_dev.sv
// Purpose: serial eeprom slave write path, device end of the link
// Assumes: link logic clocked by scl; write timer on mclk; memory outside
// Notes: no reset pin on the link side, its flops start from declared values
// Function
// - host changes data only while clock low
// - data fall with clock high is start
// - data rise with clock high is stop
// - eight bits per word, ack in ninth
// - standby after power-up, read stop, write done
// - start, nine clocks, start, stop recovers
// - device word opens with 1010 type
// - next three bits match strap pins
// - last device bit selects read or write
// - ack on match, else back to standby
// - inhibit pin high blocks all writes
// - two address bytes carry word address 14..0
// - byte write: one data byte then stop
// - after stop, self-timed write ignores the bus
// - write cycle lasts at most 5 ms
// - page write: more data bytes, each acked
// - only low six address bits increment
// - page address wraps, overflow overwrites earlier
// - sample on rising clock, drive on falling
// - data output is open drain
// - inhibit pin low allows normal writes
// - no device ack while write cycle runs
`timescale 1ns/1ps
module eeprom_dev
  import eeprom_link_pkg::*;
#(
  parameter int TWR_CYCLES = TWR_CYCLES_DFLT
) (
  input wire logic mclk,
  input wire logic rst_n,
  eeprom_link_if.dev bus,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  input wire logic write_inhibit_pin,
  output logic mem_wr_en,
  output logic [WORD_ADDR_W-1:0] mem_wr_addr,
  output logic [WORD_BITS-1:0] mem_wr_data,
  output logic write_busy,
  output logic standby
);
  localparam int PIN_W = STRAP_W + 2;
  localparam int MS_W = 3;
  localparam int TMR_W = $clog2(TWR_CYCLES + 1);

  // ---------------- start / stop detection on data-line edges ----------------
  logic start_tog_r = 1'b0;
  logic stop_tog_r = 1'b0;
  logic start_seen_r = 1'b0;
  logic stop_seen_r = 1'b0;

  always_ff @(negedge bus.sda) begin
    if (bus.scl) begin
      start_tog_r <= !start_tog_r;
    end
  end

  always_ff @(posedge bus.sda) begin
    if (bus.scl) begin
      stop_tog_r <= !stop_tog_r;
    end
  end

  logic start_pend;
  logic stop_pend;
  assign start_pend = start_tog_r ^ start_seen_r;
  assign stop_pend = stop_tog_r ^ stop_seen_r;

  always_ff @(posedge bus.scl) begin
    start_seen_r <= start_tog_r;
    stop_seen_r <= stop_tog_r;
  end

  // ---------------- pins and busy level into the link domain ----------------
  logic [PIN_W-1:0] pin_s1_r = '0;
  logic [PIN_W-1:0] pin_s2_r = '0;
  logic [PIN_W-1:0] pin_s3_r = '0;
  logic [PIN_W-1:0] pin_f_r = '0;
  logic busy_r;
  logic busy_s;
  logic inhibit_s;
  logic [STRAP_W-1:0] strap_s;

  always_ff @(posedge bus.scl) begin
    pin_s1_r <= {busy_r, write_inhibit_pin, chip_select_strap_2, chip_select_strap_1,
                 chip_select_strap_0};
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
    // a change counts once the second and third stages agree
    pin_f_r <= (~(pin_s2_r ^ pin_s3_r) & pin_s3_r) | ((pin_s2_r ^ pin_s3_r) & pin_f_r);
  end

  assign busy_s = pin_f_r[STRAP_W+1];
  assign inhibit_s = pin_f_r[STRAP_W];
  assign strap_s = pin_f_r[STRAP_W-1:0];

  // ---------------- receive engine, rising edge of scl ----------------
  dev_phase_t phase_r = ph_idle;
  dev_phase_t phase_nxt;
  logic active_r = 1'b0;
  logic [3:0] bit_cnt_r = '0;
  logic [3:0] bit_cnt_nxt;
  logic [WORD_BITS-1:0] shift_r = '0;
  logic ack_r = 1'b0;
  logic ack_clk;

  // ninth rising edge of a word that this end acknowledged
  assign ack_clk = !start_pend && !stop_pend && (phase_r != ph_idle) &&
                   (bit_cnt_r == ACK_SLOT) && ack_r;

  always_comb begin
    phase_nxt = phase_r;
    bit_cnt_nxt = bit_cnt_r;
    if (start_pend) begin
      phase_nxt = ph_dev;
      bit_cnt_nxt = 4'h1;
    end else if (stop_pend || phase_r == ph_idle) begin
      phase_nxt = ph_idle;
      bit_cnt_nxt = '0;
    end else if (bit_cnt_r != ACK_SLOT) begin
      bit_cnt_nxt = bit_cnt_r + 4'h1;
    end else begin
      bit_cnt_nxt = '0;
      if (!ack_r) begin
        phase_nxt = ph_idle;
      end else begin
        case (phase_r)
          // a read is acknowledged, then the line is released
          ph_dev: phase_nxt = shift_r[RW_POS] ? ph_idle : ph_addr_hi;
          ph_addr_hi: phase_nxt = ph_addr_lo;
          ph_addr_lo: phase_nxt = ph_data;
          ph_data: phase_nxt = ph_data;
          default: phase_nxt = ph_idle;
        endcase
      end
    end
  end

  always_ff @(posedge bus.scl) begin
    phase_r <= phase_nxt;
    bit_cnt_r <= bit_cnt_nxt;
    active_r <= (phase_nxt != ph_idle);
  end

  always_ff @(posedge bus.scl) begin
    if (start_pend) begin
      shift_r <= {{(WORD_BITS-1){1'b0}}, bus.sda};
    end else if (phase_r != ph_idle && bit_cnt_r != ACK_SLOT) begin
      shift_r <= {shift_r[WORD_BITS-2:0], bus.sda};
    end
  end

  // ---------------- acknowledge, falling edge of scl ----------------
  logic ack_ok;

  always_comb begin
    case (phase_r)
      ph_dev: ack_ok = (shift_r[WORD_BITS-1:TYPE_LSB] == DEV_TYPE_CODE) &&
                       (shift_r[TYPE_LSB-1:STRAP_LSB] == strap_s) &&
                       !busy_s;
      ph_addr_hi: ack_ok = 1'b1;
      ph_addr_lo: ack_ok = 1'b1;
      ph_data: ack_ok = !inhibit_s;
      default: ack_ok = 1'b0;
    endcase
  end

  always_ff @(negedge bus.scl) begin
    ack_r <= !start_pend && (phase_r != ph_idle) && (bit_cnt_r == ACK_SLOT) && ack_ok;
  end

  // only pulls low or releases
  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe = ack_r;

  // ---------------- word address and page buffer ----------------
  logic [WORD_ADDR_W-1:0] waddr_r = '0;
  logic [WORD_BITS-1:0] page_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_r = '0;
  logic wframe_tog_r = 1'b0;

  always_ff @(posedge bus.scl) begin
    if (ack_clk) begin
      case (phase_r)
        ph_addr_hi: waddr_r[WORD_ADDR_W-1:WORD_BITS] <= shift_r[HI_ADDR_W-1:0];
        ph_addr_lo: waddr_r[WORD_BITS-1:0] <= shift_r;
        // low bits wrap inside the page, row bits are kept
        ph_data: waddr_r[PAGE_AW-1:0] <= waddr_r[PAGE_AW-1:0] + 1'b1;
        default: waddr_r <= waddr_r;
      endcase
    end
  end

  always_ff @(posedge bus.scl) begin
    if (ack_clk && phase_r == ph_data) begin
      page_mem[waddr_r[PAGE_AW-1:0]] <= shift_r;
    end
  end

  always_ff @(posedge bus.scl) begin
    if (ack_clk && phase_r == ph_dev && !shift_r[RW_POS]) begin
      page_vld_r <= '0;
      wframe_tog_r <= !wframe_tog_r;
    end else if (ack_clk && phase_r == ph_data) begin
      page_vld_r[waddr_r[PAGE_AW-1:0]] <= 1'b1;
    end
  end

  // ---------------- link events into the system clock domain ----------------
  logic [MS_W-1:0] ms_s1_r;
  logic [MS_W-1:0] ms_s2_r;
  logic [MS_W-1:0] ms_s3_r;
  logic [MS_W-1:0] ms_f_r;
  logic stop_prev_r;
  logic wframe_done_r;
  logic stop_evt;
  logic commit;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ms_s1_r <= '0;
      ms_s2_r <= '0;
      ms_s3_r <= '0;
      ms_f_r <= '0;
      stop_prev_r <= 1'b0;
      wframe_done_r <= 1'b0;
    end else begin
      // a stop ends the frame even though no further clock follows it
      ms_s1_r <= {active_r && !stop_pend, wframe_tog_r, stop_tog_r};
      ms_s2_r <= ms_s1_r;
      ms_s3_r <= ms_s2_r;
      ms_f_r <= (~(ms_s2_r ^ ms_s3_r) & ms_s3_r) | ((ms_s2_r ^ ms_s3_r) & ms_f_r);
      stop_prev_r <= ms_f_r[0];
      if (stop_evt) begin
        wframe_done_r <= ms_f_r[1];
      end
    end
  end

  // the buffer is frozen from the stop on: no further ack until busy clears
  assign stop_evt = ms_f_r[0] != stop_prev_r;
  assign commit = stop_evt && !busy_r && (ms_f_r[1] != wframe_done_r) && (|page_vld_r);

  // ---------------- self-timed write cycle ----------------
  logic [TMR_W-1:0] tmr_r;
  logic [PAGE_AW:0] walk_r;
  logic [WORD_ADDR_W-PAGE_AW-1:0] row_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      tmr_r <= '0;
    end else if (commit) begin
      busy_r <= 1'b1;
      tmr_r <= '0;
    end else if (busy_r) begin
      tmr_r <= tmr_r + 1'b1;
      if (tmr_r == TMR_W'(TWR_CYCLES - 1)) begin
        busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      walk_r <= (PAGE_AW+1)'(PAGE_BYTES);
      row_r <= '0;
    end else if (commit) begin
      walk_r <= '0;
      row_r <= waddr_r[WORD_ADDR_W-1:PAGE_AW];
    end else if (walk_r != (PAGE_AW+1)'(PAGE_BYTES)) begin
      walk_r <= walk_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_wr_en <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= '0;
    end else begin
      mem_wr_en <= (walk_r != (PAGE_AW+1)'(PAGE_BYTES)) && page_vld_r[walk_r[PAGE_AW-1:0]];
      mem_wr_addr <= {row_r, walk_r[PAGE_AW-1:0]};
      mem_wr_data <= page_mem[walk_r[PAGE_AW-1:0]];
    end
  end

  assign write_busy = busy_r;
  assign standby = !busy_r && !ms_f_r[2];
endmodule

// File: eeprom_host.sv
// Purpose: two-wire bus master end driving the eeprom link
// Assumes: link clock derived from mclk by a quarter-period divider
// Notes: one command at a time; byte reads are not supported
`timescale 1ns/1ps
module eeprom_host
  import eeprom_link_pkg::*;
#(
  parameter int QUARTER_CYCLES = QUARTER_CYCLES_DFLT
) (
  input wire logic mclk,
  input wire logic rst_n,
  eeprom_link_if.host bus,
  input wire logic cmd_valid,
  input wire host_op_t cmd_op,
  input wire logic [WORD_BITS-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_nack
);
  localparam int DIV_W = $clog2(QUARTER_CYCLES + 1);

  logic [2:0] sda_s_r;
  logic sda_f_r;
  logic [DIV_W-1:0] div_r;
  logic tick;
  host_state_t state_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [WORD_BITS:0] shift_r;
  logic scl_r;
  logic oe_r;
  logic samp_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sda_s_r <= 3'h7;
      sda_f_r <= 1'b1;
    end else begin
      sda_s_r <= {sda_s_r[1:0], bus.sda};
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || div_r == DIV_W'(QUARTER_CYCLES - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign tick = div_r == DIV_W'(QUARTER_CYCLES - 1);
  assign cmd_ready = state_r == st_idle;

  // each step is four quarters; bit data moves with the clock low, start and stop move it with the clock high
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= st_idle;
      q_r <= '0;
      bit_r <= '0;
      shift_r <= '1;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      samp_r <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_r == st_idle) begin
        q_r <= '0;
        bit_r <= '0;
        if (cmd_valid) begin
          case (cmd_op)
            op_start: state_r <= st_start;
            op_stop: state_r <= st_stop;
            op_write: state_r <= st_bit;
            op_clocks: state_r <= st_bit;
            default: state_r <= st_idle;
          endcase
          shift_r <= (cmd_op == op_write) ? {cmd_data, 1'b1} : '1;
        end
      end else if (tick) begin
        q_r <= q_r + 2'h1;
        case (state_r)
          st_start: begin
            case (q_r)
              2'h0: oe_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b1;
              default: scl_r <= 1'b0;
            endcase
          end
          st_stop: begin
            case (q_r)
              2'h0: oe_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b0;
              default: scl_r <= 1'b1;
            endcase
          end
          st_bit: begin
            case (q_r)
              2'h0: oe_r <= !shift_r[WORD_BITS];
              2'h1: scl_r <= 1'b1;
              2'h2: samp_r <= sda_f_r;
              default: begin
                scl_r <= 1'b0;
                shift_r <= {shift_r[WORD_BITS-1:0], 1'b1};
                bit_r <= bit_r + 4'h1;
              end
            endcase
          end
          default: state_r <= st_idle;
        endcase
        if (q_r == 2'h3 && (state_r != st_bit || bit_r == 4'(SOFT_RESET_CLOCKS - 1))) begin
          state_r <= st_idle;
          rsp_valid <= 1'b1;
          rsp_nack <= (state_r == st_bit) ? samp_r : 1'b0;
        end
      end
    end
  end

  assign bus.scl = scl_r;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = oe_r;
endmodule

// File: eeprom_link_properties.sv
// Purpose: wire-level checks on the two-wire eeprom link
// Assumes: scl made by the host from mclk, so mclk samples every link edge
// Notes: a helper counts scl rises per word; start clears it
`timescale 1ns/1ps
module eeprom_link_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_r;
  logic start_det;
  logic stop_det;

  assign start_det = scl && scl_q && sda_q && !sda;
  assign stop_det = scl && scl_q && !sda_q && sda;

  always_ff @(posedge mclk) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // ninth rise of a word reads 9, the next rise starts again at 1
  always_ff @(posedge mclk) begin
    if (!rst_n || start_det) begin
      cnt_r <= 4'h0;
    end else if (scl && !scl_q) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_dev_open_drain: assert property (sda_d_oe |-> !sda_d_o)
    else $error("device drove the data line high");
  a_dev_falling_edge: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device changed data while clock high");
  a_ack_in_slot: assert property (sda_d_oe |-> cnt_r inside {4'h8, 4'h9})
    else $error("device drove outside the ack slot");
  a_ack_high_ninth: assert property (sda_d_oe && scl && scl_q |-> cnt_r == 4'h9)
    else $error("device ack high phase not on ninth clock");
  a_ack_one_period: assert property ($rose(sda_d_oe) |-> ##36 sda_d_oe ##[1:8] !sda_d_oe)
    else $error("ack did not last one clock period");
  a_bit_stable_high: assert property (scl && scl_q && cnt_r inside {[4'h2:4'h8]} |-> $stable(sda))
    else $error("data changed while clock high in a word");
  a_start_hold: assert property (start_det |-> ##1 scl[*2])
    else $error("clock fell too soon after start");
  a_stop_bus_free: assert property (stop_det |-> sda[*8])
    else $error("bus not left free after stop");

  c_start: cover property (start_det);
  c_stop: cover property (stop_det);
  c_ack: cover property ($rose(sda_d_oe));
  c_nack: cover property (scl && scl_q && cnt_r == 4'h9 && sda);
endmodule

// File: test_serial_eeprom_slave_write_path.sv
// Purpose: host end against device end of the eeprom write path
// Assumes: straps 101, write cycle shortened to TWR mclk cycles
// Notes: byte writes are captured from the device's memory port
`timescale 1ns/1ps
module test_serial_eeprom_slave_write_path
  import eeprom_link_pkg::*;
;
  localparam int INTERNAL_WRITE_CYCLE_TIME = 1000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic inhibit = 1'b0;
  logic cmd_valid = 1'b0;
  host_op_t cmd_op = op_start;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, rsp_nack, mem_wr_en, write_busy, standby, bq;
  logic [14:0] mem_wr_addr;
  logic [7:0] mem_wr_data;
  logic [22:0] wq[$];
  int fails = 0;
  int cmp_count = 0;
  int bcnt = 0;

  eeprom_link_if link ();
  eeprom_dev #(.TWR_CYCLES(INTERNAL_WRITE_CYCLE_TIME)) eeprom_dev_inst (.mclk(mclk), .rst_n(rst_n), .bus(link),
    .chip_select_strap_0(1'b1), .chip_select_strap_1(1'b0), .chip_select_strap_2(1'b1),
    .write_inhibit_pin(inhibit), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .write_busy(write_busy), .standby(standby));
  eeprom_host #(.QUARTER_CYCLES(10)) eeprom_host_inst (.mclk(mclk), .rst_n(rst_n),
    .bus(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack));
  eeprom_link_properties eeprom_link_properties_inst (.mclk(mclk), .rst_n(rst_n),
    .scl(link.scl), .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
    .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe), .sda(link.sda));

  always #12.5 mclk = ~mclk;

  // busy length and the memory writes of each cycle
  always @(posedge mclk) begin
    bq <= write_busy;
    if (write_busy === 1'b1) bcnt <= (bq === 1'b1) ? bcnt + 1 : 1;
    if (mem_wr_en === 1'b1) wq.push_back({mem_wr_addr, mem_wr_data});
  end

  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // entered and left just after a clock edge
  task automatic cmd(input host_op_t o, input logic [7:0] d, output logic nack);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_data = d;
    while (cmd_ready !== 1'b1 && n < 2000) begin @(posedge mclk); #1; n++; end
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 4000) begin @(posedge mclk); #1; n++; end
    nack = rsp_nack;
  endtask

  task automatic op(input host_op_t o);
    logic n;
    cmd(o, 8'h00, n);
  endtask

  task automatic wr(input logic [7:0] d, input logic e);
    logic n;
    cmd(op_write, d, n);
    check(23'(n), 23'(e));
  endtask

  task automatic head(input logic [7:0] hi, input logic [7:0] lo);
    op(op_start);
    wr(8'hAA, 1'b0);
    wr(hi, 1'b0);
    wr(lo, 1'b0);
  endtask

  // lets a write cycle begin, then waits it out
  task automatic settle;
    int n;
    n = 0;
    repeat (12) @(posedge mclk);
    #1;
    while (write_busy !== 1'b0 && n < 3000) begin @(posedge mclk); #1; n++; end
  endtask

  initial begin
    int k;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    head(8'h12, 8'h34);
    op(op_start);
    op(op_clocks);
    op(op_start);
    op(op_stop);
    settle;
    check(23'(wq.size()), 23'h0);
    head(8'h12, 8'h34);
    wr(8'h5C, 1'b0);
    op(op_stop);
    op(op_start);
    wr(8'hAA, 1'b1);
    op(op_stop);
    settle;
    check(23'(bcnt), 23'(INTERNAL_WRITE_CYCLE_TIME));
    check(23'(standby), 23'h1);
    check(23'(wq.size()), 23'h1);
    check(wq[0], {15'h1234, 8'h5C});
    wq.delete();
    head(8'h05, 8'hFE);
    for (k = 0; k < 66; k++) wr(8'(k), 1'b0);
    op(op_stop);
    settle;
    check(23'(wq.size()), 23'h40);
    check(23'(standby), 23'h1);
    for (k = 0; k < 64; k++) check(wq[k], {7'h05, 2'b11, 6'(k), 8'(k + 2)});
    wq.delete();
    inhibit = 1'b1;
    head(8'h05, 8'h00);
    wr(8'h77, 1'b1);
    op(op_stop);
    settle;
    check(23'(wq.size()), 23'h0);
    inhibit = 1'b0;
    op(op_start);
    wr(8'hAB, 1'b0);
    op(op_stop);
    settle;
    check(23'(standby), 23'h1);
    for (k = 1; k < 8; k++) begin
      op(op_start);
      wr(8'hAA ^ 8'(1 << k), 1'b1);
      op(op_stop);
      check(23'(standby), 23'h1);
    end
    check(23'(wq.size()), 23'h0);
    test_done;
  end

  initial begin
    #2000000;
    fails++;
    test_done;
  end
endmodule
